// File: rtl/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

    // Register indices as seen from the serial management path
    localparam logic [4:0] REG_CONTROL       = 5'h00;
    localparam logic [4:0] REG_STATUS        = 5'h01;
    localparam logic [4:0] REG_IDENT_HIGH    = 5'h02;
    localparam logic [4:0] REG_IDENT_LOW     = 5'h03;
    localparam logic [4:0] REG_ADVERTISEMENT = 5'h04;
    localparam logic [4:0] REG_PARTNER       = 5'h05;

    // Status register field positions
    localparam int STAT_FOUR_PAIR   = 15;
    localparam int STAT_CAP_HI      = 14;
    localparam int STAT_CAP_LO      = 11;
    localparam int STAT_NEG_DONE    = 5;
    localparam int STAT_FAR_FAULT   = 4;
    localparam int STAT_NEG_ABILITY = 3;
    localparam int STAT_LINK_UP     = 2;

    // Advertisement and partner field positions
    localparam int ADV_PAUSE        = 10;
    localparam int ADV_ABIL_HI      = 8;
    localparam int ADV_ABIL_LO      = 5;
    localparam int ADV_SEL_HI       = 4;

    // Fixed parts of the status word: four ability bits and negotiation ability
    localparam logic [15:0] STATUS_FIXED   = 16'h7808;
    // Values after reset of the writable and captured fields
    localparam logic        ADV_PAUSE_RST  = 1'b1;
    localparam logic [3:0]  ADV_ABIL_RST   = 4'hf;
    localparam logic        PART_PAUSE_RST = 1'b0;
    localparam logic [3:0]  PART_ABIL_RST  = 4'h0;
    // Read-only selector field of the advertisement word
    localparam logic [4:0]  ADV_SELECTOR   = 5'h01;
    // Low five bits of the partner word always read this value
    localparam logic [4:0]  PART_LOW_BITS  = 5'h01;

    // SPI path: registers of one port start at this byte address
    localparam logic [7:0]  SPI_PORT_BASE  = 8'h00;
    localparam logic [7:0]  SPI_PORT_SPAN  = 8'h06;

endpackage

// File: rtl/partner_capture.sv
`timescale 1ns/1ps
`default_nettype none

// Latches the partner's received abilities when negotiation finishes
module partner_capture (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       negotiation_done,
    input  wire logic [4:0] partner_word,
    output logic            part_pause,
    output logic [3:0]      part_abil
);

    logic done_d_r;

    // Delayed completion flag for the rising edge
    // Resets high so a level already high at release is not taken as an edge
    always_ff @(posedge clk) begin
        if (srst) begin
            done_d_r <= 1'b1; // [R16]
        end else begin
            done_d_r <= negotiation_done;
        end
    end

    // Capture once per completion; value holds until the next one
    always_ff @(posedge clk) begin
        if (srst) begin
            part_pause <= phy_mgmt_pkg::PART_PAUSE_RST; // [R12]
            part_abil  <= phy_mgmt_pkg::PART_ABIL_RST;  // [R13]
        end else if (negotiation_done && !done_d_r) begin
            part_pause <= partner_word[4];   // [R16]
            part_abil  <= partner_word[3:0]; // [R16]
        end
    end

endmodule

`default_nettype wire

// File: rtl/phy_mgmt_status_ability_regs.sv
// Operation
// [R01] Status bit 15 always reads zero: no four-pair mode.
// [R02] Status bits 14..11 read one, fixed duplex and speed abilities.
// [R03] Status bit 5 shows negotiation finished; resets zero; not writable.
// [R04] Status bit 4 shows far-end fault detected; resets zero.
// [R05] Status bit 3 reads one: port can auto-negotiate.
// [R06] Status bit 2 shows link up; resets zero.
// [R07] Status bit 0, bits 10..7, bits 6 and 1 read zero.
// [R08] Index 2 returns upper sixteen identifier bits, read-only.
// [R09] Index 3 returns lower sixteen identifier bits, read-only.
// [R10] Advertisement bit 10, pause, writable, resets to one.
// [R11] Advertisement bits 8..5 writable, reset one, select advertised abilities.
// [R12] Partner bit 10 read-only, resets zero, shows partner pause.
// [R13] Partner bits 8..5 read-only, reset zero, show partner abilities.
// [R14] Advertisement selector field bits 4..0 read-only, value one.
// [R15] Unsupported and reserved bits of indices 4, 5 ignore writes.
// [R16] Partner bits captured from received word when negotiation completes.
// [R17] Every register reachable from serial management and SPI, mapped differently.
`timescale 1ns/1ps
`default_nettype none

module phy_mgmt_status_ability_regs #(
    parameter logic [4:0]  PORT_ADDR  = 5'h01,
    parameter logic [7:0]  SPI_BASE   = phy_mgmt_pkg::SPI_PORT_BASE,
    parameter logic [15:0] IDENT_HIGH = 16'h1234, // arbitrary value
    parameter logic [15:0] IDENT_LOW  = 16'h5670  // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        srst,
    // Serial management access, decoded frame fields
    input  wire logic        mgmt_req,
    input  wire logic        mgmt_write,
    input  wire logic [4:0]  mgmt_phy_addr,
    input  wire logic [4:0]  mgmt_reg_addr,
    input  wire logic [15:0] mgmt_wdata,
    output logic             mgmt_rvalid,
    output logic [15:0]      mgmt_rdata,
    // SPI access, decoded byte address
    input  wire logic        spi_req,
    input  wire logic        spi_write,
    input  wire logic [7:0]  spi_addr,
    input  wire logic [15:0] spi_wdata,
    output logic             spi_rvalid,
    output logic [15:0]      spi_rdata,
    // Port state from the negotiation engine and receiver
    input  wire logic        link_up,
    input  wire logic        far_end_fault,
    input  wire logic        negotiation_done,
    input  wire logic [15:0] partner_rx_word,
    // Advertised abilities towards the negotiation engine
    output logic             adv_pause,
    output logic [3:0]       adv_abil
);

    logic        link_r;
    logic        fault_r;
    logic        done_r;
    logic        part_pause;
    logic [3:0]  part_abil;
    logic        mgmt_hit;
    logic        spi_hit;
    logic [7:0]  spi_off;
    logic [4:0]  spi_idx;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [15:0] wr_data;
    logic [15:0] status_word;
    logic [15:0] adv_word;
    logic [15:0] part_word;

    // Port state mirrored into flops; all clear at reset
    always_ff @(posedge clk) begin
        if (srst) begin
            link_r  <= 1'b0; // [R06]
            fault_r <= 1'b0; // [R04]
            done_r  <= 1'b0; // [R03]
        end else begin
            link_r  <= link_up;          // [R06]
            fault_r <= far_end_fault;    // [R04]
            done_r  <= negotiation_done; // [R03]
        end
    end

    // Partner ability capture on completion
    partner_capture u_capture (
        .clk              (clk),
        .srst             (srst),
        .negotiation_done (negotiation_done),
        .partner_word     ({partner_rx_word[phy_mgmt_pkg::ADV_PAUSE],
                            partner_rx_word[phy_mgmt_pkg::ADV_ABIL_HI:phy_mgmt_pkg::ADV_ABIL_LO]}),
        .part_pause       (part_pause),
        .part_abil        (part_abil)
    );

    // Address decode for both paths
    always_comb begin
        mgmt_hit = mgmt_req && (mgmt_phy_addr == PORT_ADDR);    // [R17]
        spi_off  = spi_addr - SPI_BASE;                          // [R17]
        spi_hit  = spi_req && (spi_addr >= SPI_BASE)
                   && (spi_off < phy_mgmt_pkg::SPI_PORT_SPAN);  // [R17]
        spi_idx  = spi_off[4:0];
    end

    // One write port; serial management wins a same-cycle collision
    always_comb begin
        wr_en   = 1'b0;
        wr_idx  = 5'h00;
        wr_data = 16'h0000;
        if (mgmt_hit && mgmt_write) begin
            wr_en   = 1'b1;
            wr_idx  = mgmt_reg_addr;
            wr_data = mgmt_wdata;
        end else if (spi_hit && spi_write) begin
            wr_en   = 1'b1;
            wr_idx  = spi_idx;
            wr_data = spi_wdata;
        end
    end

    // Only pause and the four ability bits store; other bits drop writes
    always_ff @(posedge clk) begin
        if (srst) begin
            adv_pause <= phy_mgmt_pkg::ADV_PAUSE_RST; // [R10]
            adv_abil  <= phy_mgmt_pkg::ADV_ABIL_RST;  // [R11]
        end else if (wr_en && wr_idx == phy_mgmt_pkg::REG_ADVERTISEMENT) begin
            adv_pause <= wr_data[phy_mgmt_pkg::ADV_PAUSE]; // [R10]
            adv_abil  <= wr_data[phy_mgmt_pkg::ADV_ABIL_HI:phy_mgmt_pkg::ADV_ABIL_LO]; // [R11]
        end
    end

    // Read words; unlisted bits are constant zero
    always_comb begin
        status_word = phy_mgmt_pkg::STATUS_FIXED; // [R01] [R02] [R05] [R07]
        status_word[phy_mgmt_pkg::STAT_NEG_DONE]  = done_r;  // [R03]
        status_word[phy_mgmt_pkg::STAT_FAR_FAULT] = fault_r; // [R04]
        status_word[phy_mgmt_pkg::STAT_LINK_UP]   = link_r;  // [R06]
        adv_word = 16'h0000; // [R15]
        adv_word[phy_mgmt_pkg::ADV_PAUSE] = adv_pause; // [R10]
        adv_word[phy_mgmt_pkg::ADV_ABIL_HI:phy_mgmt_pkg::ADV_ABIL_LO] = adv_abil; // [R11]
        adv_word[phy_mgmt_pkg::ADV_SEL_HI:0] = phy_mgmt_pkg::ADV_SELECTOR; // [R14]
        part_word = 16'h0000; // [R15]
        part_word[phy_mgmt_pkg::ADV_PAUSE] = part_pause; // [R12]
        part_word[phy_mgmt_pkg::ADV_ABIL_HI:phy_mgmt_pkg::ADV_ABIL_LO] = part_abil; // [R13]
        part_word[phy_mgmt_pkg::ADV_SEL_HI:0] = phy_mgmt_pkg::PART_LOW_BITS; // [R15]
    end

    // Shared read multiplexer; reads see pre-write contents
    function automatic logic [15:0] read_word(input logic [4:0] idx,
                                              input logic [15:0] st,
                                              input logic [15:0] ad,
                                              input logic [15:0] pw);
        case (idx)
            phy_mgmt_pkg::REG_STATUS:        read_word = st;
            phy_mgmt_pkg::REG_IDENT_HIGH:    read_word = IDENT_HIGH; // [R08]
            phy_mgmt_pkg::REG_IDENT_LOW:     read_word = IDENT_LOW;  // [R09]
            phy_mgmt_pkg::REG_ADVERTISEMENT: read_word = ad;
            phy_mgmt_pkg::REG_PARTNER:       read_word = pw;
            default:                         read_word = 16'h0000;
        endcase
    endfunction

    // Serial management answer, one cycle after the request
    always_ff @(posedge clk) begin
        if (srst) begin
            mgmt_rvalid <= 1'b0;
            mgmt_rdata  <= 16'h0000;
        end else begin
            mgmt_rvalid <= mgmt_hit && !mgmt_write;
            if (mgmt_hit && !mgmt_write) begin
                mgmt_rdata <= read_word(mgmt_reg_addr, status_word,
                                        adv_word, part_word); // [R17]
            end
        end
    end

    // SPI answer, one cycle after the request
    always_ff @(posedge clk) begin
        if (srst) begin
            spi_rvalid <= 1'b0;
            spi_rdata  <= 16'h0000;
        end else begin
            spi_rvalid <= spi_hit && !spi_write;
            if (spi_hit && !spi_write) begin
                spi_rdata <= read_word(spi_idx, status_word,
                                       adv_word, part_word); // [R17]
            end
        end
    end

endmodule

`default_nettype wire

// File: tb/phy_mgmt_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Cycle relations of both access paths and the advertised outputs
module phy_mgmt_sva #(
    parameter logic [4:0]  PORT_ADDR  = 5'h01,
    parameter logic [15:0] IDENT_HIGH = 16'h1234
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        mgmt_req, mgmt_write, mgmt_rvalid,
    input wire logic [4:0]  mgmt_phy_addr, mgmt_reg_addr,
    input wire logic [15:0] mgmt_wdata, mgmt_rdata,
    input wire logic        spi_req, spi_write, spi_rvalid,
    input wire logic [7:0]  spi_addr,
    input wire logic        link_up, far_end_fault, negotiation_done,
    input wire logic        adv_pause,
    input wire logic [3:0]  adv_abil
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Decoded requests; spi base assumed at zero
    wire logic mrd = mgmt_req && !mgmt_write && mgmt_phy_addr == PORT_ADDR;
    wire logic mwa = mgmt_req && mgmt_write && mgmt_phy_addr == PORT_ADDR && mgmt_reg_addr == 5'h04;
    wire logic swa = spi_req && spi_write && spi_addr == 8'h04;

    a_mgmt_read_answer: assert property (mrd |=> mgmt_rvalid)
        else $error("mgmt read not answered");
    a_mgmt_no_answer: assert property (!mrd |=> !mgmt_rvalid)
        else $error("mgmt answer without read");
    a_spi_read_answer: assert property (spi_req && !spi_write && spi_addr < 8'h06 |=> spi_rvalid)
        else $error("spi read not answered");
    a_status_fixed_bits: assert property (mrd && mgmt_reg_addr == 5'h01 |=> (mgmt_rdata & 16'hffcb) == 16'h7808)
        else $error("status fixed bits wrong");
    a_status_live_bits: assert property (mrd && mgmt_reg_addr == 5'h01 && !$past(srst)
        |=> {mgmt_rdata[5:4], mgmt_rdata[2]} == {$past(negotiation_done, 2), $past(far_end_fault, 2), $past(link_up, 2)})
        else $error("status live bits wrong");
    a_ident_high_read: assert property (mrd && mgmt_reg_addr == 5'h02 |=> mgmt_rdata == IDENT_HIGH)
        else $error("identifier high wrong");
    a_adv_write_lands: assert property (mwa |=> {adv_pause, adv_abil} == {$past(mgmt_wdata[10]), $past(mgmt_wdata[8:5])})
        else $error("advertisement write lost");
    a_adv_hold_value: assert property (!srst && !mwa && !swa |=> $stable({adv_pause, adv_abil}))
        else $error("advertisement changed without write");
endmodule

`default_nettype wire

// File: tb/neg_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

// Negotiation engine stand-in; partner word is only valid on the rising cycle
module neg_engine_model (
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic        fault,
    input  wire logic [15:0] word,
    output logic             link_up,
    output logic             far_end_fault,
    output logic             negotiation_done,
    output logic [15:0]      partner_rx_word
);
    assign far_end_fault = fault; // Line monitor level
    // Restart drops link and done, then completes two cycles later
    initial begin
        link_up = 1'b0;
        negotiation_done = 1'b0;
        partner_rx_word = 16'h0000;
        forever begin
            @(posedge clk);
            if (start) begin
                #2 negotiation_done = 1'b0;
                link_up = 1'b0;
                partner_rx_word = ~word;
                repeat (2) @(posedge clk);
                #2 partner_rx_word = word;
                negotiation_done = 1'b1;
                link_up = 1'b1;
                @(posedge clk);
                #2 partner_rx_word = ~word; // Not kind: word changes after capture
            end
        end
    end
endmodule

`default_nettype wire

// File: tb/phy_mgmt_status_ability_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module phy_mgmt_status_ability_regs_tb_top;
    logic        clk = 1'b0, srst = 1'b1, start = 1'b0, fault = 1'b0;
    logic        mgmt_req = 1'b0, mgmt_write = 1'b0, spi_req = 1'b0, spi_write = 1'b0;
    logic [4:0]  mgmt_phy_addr = 5'h01, mgmt_reg_addr = 5'h00, phy_sel = 5'h01;
    logic [7:0]  spi_addr = 8'h00;
    logic [15:0] mgmt_wdata = 16'h0000, spi_wdata = 16'h0000, word = 16'h0000;
    logic [15:0] adv_e = 16'h05e1, part_e = 16'h0001, d;
    wire logic   mgmt_rvalid, spi_rvalid, link_up, far_end_fault, negotiation_done, adv_pause;
    wire logic [15:0] mgmt_rdata, spi_rdata, partner_rx_word;
    wire logic [3:0]  adv_abil;
    logic [15:0] mq[$], sq[$];
    int          failures = 0, compares = 0, k;

    always #12.5 clk = ~clk;
    phy_mgmt_status_ability_regs uut (.*);
    neg_engine_model eng (.*);

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        if (failures == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Expected read value of an index from the bench's own view
    function logic [15:0] ex(input int a);
        case (a)
            1: ex = 16'h7808 | {10'h0, negotiation_done, far_end_fault, 1'b0, link_up, 2'b0};
            2: ex = 16'h1234;
            3: ex = 16'h5670;
            4: ex = adv_e;
            5: ex = part_e;
            default: ex = 16'h0000;
        endcase
    endfunction
    // One cycle of requests on both paths, launched a fixed delay after the edge
    task cyc(input logic mr, mw, input logic [4:0] ma, input logic [15:0] md,
             input logic sr, sw, input logic [7:0] sa, input logic [15:0] sd);
        #2 mgmt_req = mr;
        mgmt_write = mw;
        mgmt_reg_addr = ma;
        mgmt_phy_addr = phy_sel; // Address moves with the request, never on the edge
        mgmt_wdata = md;
        spi_req = sr;
        spi_write = sw;
        spi_addr = sa;
        spi_wdata = sd;
        @(posedge clk);
    endtask
    task mrd(input logic [4:0] a);
        mq.push_back(ex(a));
        cyc(1, 0, a, 0, 0, 0, 0, 0);
    endtask
    task srd(input logic [7:0] a);
        sq.push_back(ex(a));
        cyc(0, 0, 0, 0, 1, 0, a, 0);
    endtask
    task idle;
        cyc(0, 0, 0, 0, 0, 0, 0, 0);
    endtask

    // Answers are matched against the oldest expectation of their path
    always @(posedge clk) begin
        if (mgmt_rvalid === 1'b1) begin
            if (mq.size() == 0) chk("mgmt_rvalid", 16'h0001, 16'h0000);
            else chk("mgmt_rdata", mgmt_rdata, mq.pop_front());
        end
        if (spi_rvalid === 1'b1) begin
            if (sq.size() == 0) chk("spi_rvalid", 16'h0001, 16'h0000);
            else chk("spi_rdata", spi_rdata, sq.pop_front());
        end
    end

    initial begin
        void'($urandom(84));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        // Reset values on every index, back to back, then refused requests
        for (int i = 0; i < 32; i++) mrd(i[4:0]);
        phy_sel = 5'h02;
        cyc(1, 0, 5'h01, 0, 1, 0, 8'h06, 0);
        phy_sel = 5'h01;
        for (int i = 0; i < 6; i++) srd(i[7:0]);
        // Random writes over either path; only the writable bits may stick
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            k = $urandom_range(1, 5);
            if (i[0]) cyc(1, 1, k[4:0], d, 0, 0, 0, 0);
            else cyc(0, 0, 0, 0, 1, 1, k[7:0], d);
            if (k == 4) adv_e = (d & 16'h05e0) | 16'h0001;
            mrd(k[4:0]);
            chk("adv_out", {11'h0, adv_pause, adv_abil}, {11'h0, adv_e[10], adv_e[8:5]});
        end
        // Same cycle writes: serial management wins
        d = 16'($urandom);
        cyc(1, 1, 5'h04, d, 1, 1, 8'h04, ~d);
        adv_e = (d & 16'h05e0) | 16'h0001;
        srd(8'h04);
        // Negotiation rounds with random partner word and fault level
        for (int r = 0; r < 3; r++) begin
            word <= 16'($urandom);
            fault <= 1'($urandom);
            start <= 1'b1;
            idle();
            start <= 1'b0;
            @(posedge clk);
            for (k = 0; k < 20 && negotiation_done !== 1'b1; k++) @(posedge clk);
            if (k == 20) begin
                failures++;
                report_and_stop();
            end
            part_e = (word & 16'h05e0) | 16'h0001;
            repeat (3) idle();
            mrd(5'h01);
            mrd(5'h05);
            srd(8'h05);
        end
        // Reset in mid-run restores defaults
        idle();
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        adv_e = 16'h05e1;
        part_e = 16'h0001;
        mrd(5'h04);
        mrd(5'h05);
        repeat (3) idle();
        chk("mgmt_queue", mq.size(), 0);
        chk("spi_queue", sq.size(), 0);
        report_and_stop();
    end
endmodule

bind phy_mgmt_status_ability_regs phy_mgmt_sva #(.PORT_ADDR(PORT_ADDR), .IDENT_HIGH(IDENT_HIGH)) chk_i (.*);

`default_nettype wire
